// ### logic/mcuor_regs.sv
// Operational register page of an 8-bit microcontroller core
`timescale 1ns/1ps
`default_nettype none

module mcuor_regs #(
   parameter int STACK_DEPTH = 8,
   parameter int PRESCALE_WIDTH = 8
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Data access from the execution core
   input wire logic [5:0] data_addr_i,
   input wire logic data_read_i,
   input wire logic data_write_i,
   input wire logic [7:0] data_wdata_i,
   input wire logic pc_low_write_i,
   output logic [7:0] data_rdata_o,
   // Flow control from the execution core
   input wire logic instr_valid_i,
   input wire mcuor_pkg::mcuor_op_type op_i,
   input wire logic [9:0] operand_i,
   input wire logic [7:0] accumulator_i,
   output logic [9:0] program_counter_o,
   output logic stall_o,
   // Status updates from the ALU
   input wire logic flags_write_i,
   input wire logic [2:0] flags_i,
   input wire logic sleep_instruction_i,
   input wire logic watchdog_clear_instruction_i,
   input wire logic watchdog_expired_i,
   input wire logic ram_select_increment_i,
   // Control page bits and pins
   input wire logic [7:0] core_control_i,
   input wire logic [7:0] interrupt_mask_i,
   input wire logic timer_pin_i,
   input wire logic ext_irq_n_i,
   input wire logic [7:0] port6_pins_i,
   output logic [7:0] port5_data_o,
   output logic [7:0] port6_data_o,
   output logic [7:0] interrupt_flags_o,
   output logic port_change_wake_o,
   output logic [PRESCALE_WIDTH-1:0] prescaler_o
);
   import mcuor_pkg::*;

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [9:0] pc;
      logic [STACK_DEPTH-1:0][9:0] stack;
      logic [7:0] timer;
      logic [PRESCALE_WIDTH-1:0] prescale;
      logic [7:0] status;
      logic [7:0] ram_select;
      logic [7:0] port5;
      logic [7:0] port6;
      logic [7:0] trim;
      logic [7:0] wakeup;
      logic [7:0] irq_flags;
      logic [2:0] tpin_sync;
      logic tpin_state;
      logic [2:0] int_sync;
      logic int_state;
      logic [7:0][2:0] p6_sync;
      logic [7:0] p6_state;
      logic [7:0] rdata;
      mcuor_fetch_type fetch;
   } mcuor_state_type;

   mcuor_state_type cur;
   mcuor_state_type next_cur;

   // General-purpose RAM kept apart: 48 bytes, no reset needed
   logic [7:0] gp_ram [ADDR_GP_FIRST:ADDR_GP_LAST];

   logic [5:0] eff_addr;
   logic [7:0] read_mux;
   logic [7:0] p6_stable;
   logic [7:0] p6_changed;
   logic tpin_stable;
   logic int_stable;

   // ----------------------------------------------------------------
   // Address resolution and pin filtering
   // ----------------------------------------------------------------
   // Indirect access uses the select pointer instead
   assign eff_addr = (data_addr_i == ADDR_INDIRECT) ?
      cur.ram_select[5:0] : data_addr_i;

   // Port-6 pins: accept change once the two later stages agree
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_p6
         assign p6_stable[gi] = cur.p6_sync[gi][1] == cur.p6_sync[gi][2];
         assign p6_changed[gi] = p6_stable[gi] &&
            (cur.p6_sync[gi][2] != cur.p6_state[gi]);
      end
   endgenerate

   assign tpin_stable = cur.tpin_sync[1] == cur.tpin_sync[2];
   assign int_stable = cur.int_sync[1] == cur.int_sync[2];

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------
   always_comb begin
      read_mux = 8'h00;
      case (eff_addr)
         ADDR_INDIRECT: read_mux = 8'h00; // Pointer at itself reads 0
         ADDR_TIMER: read_mux = cur.timer;
         ADDR_PC: read_mux = cur.pc[7:0];
         ADDR_STATUS: read_mux = cur.status;
         ADDR_RAM_SELECT: read_mux = cur.ram_select;
         ADDR_PORT5: read_mux = cur.port5 & PORT5_MASK;
         ADDR_PORT6: read_mux = cur.port6;
         ADDR_TRIM_SIM: read_mux = cur.trim & TRIM_MASK;
         ADDR_WAKEUP: read_mux = cur.wakeup & WAKEUP_MASK;
         ADDR_IRQ_FLAGS: read_mux = cur.irq_flags & interrupt_mask_i &
            IRQ_MASK;
         default: begin
            if (eff_addr >= ADDR_GP_FIRST) begin
               read_mux = gp_ram[eff_addr];
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic tick;
      logic pin_edge;
      logic timer_advance;
      logic [PRESCALE_WIDTH-1:0] ratio_mask;
      logic pc_changed;
      logic [9:0] pc_inc;
      logic [7:0] ev;
      tick = 1'b0;
      pin_edge = 1'b0;
      timer_advance = 1'b0;
      ratio_mask = '0;
      pc_changed = 1'b0;
      pc_inc = cur.pc + 10'h001;
      ev = 8'h00;
      next_cur = cur;

      // Synchroniser chains; only stages 1 and 2 are compared
      next_cur.tpin_sync = {cur.tpin_sync[1:0], timer_pin_i};
      next_cur.int_sync = {cur.int_sync[1:0], ext_irq_n_i};
      for (int i = 0; i < 8; i++) begin
         next_cur.p6_sync[i] = {cur.p6_sync[i][1:0], port6_pins_i[i]};
      end
      if (tpin_stable) begin
         next_cur.tpin_state = cur.tpin_sync[2];
      end
      if (int_stable) begin
         next_cur.int_state = cur.int_sync[2];
      end
      for (int i = 0; i < 8; i++) begin
         if (p6_stable[i]) begin
            next_cur.p6_state[i] = cur.p6_sync[i][2];
         end
      end

      // Timer source: instruction clock or selected pin edge
      if (tpin_stable && cur.tpin_sync[2] != cur.tpin_state) begin
         pin_edge = core_control_i[CTRL_EDGE_SELECT] ?
            !cur.tpin_sync[2] : cur.tpin_sync[2];
      end
      tick = core_control_i[CTRL_TIMER_SOURCE] ? pin_edge :
         instr_valid_i;

      // Prescaler sits in the timer path only when assign bit is 0
      ratio_mask = PRESCALE_WIDTH'((2 << core_control_i[2:0]) - 1);
      if (!core_control_i[CTRL_PRESCALER_ASSIGN]) begin
         if (tick) begin
            next_cur.prescale = cur.prescale + 1'b1;
            timer_advance = ((cur.prescale + 1'b1) & ratio_mask) == '0;
         end
      end else begin
         timer_advance = tick;
      end
      if (timer_advance) begin
         next_cur.timer = cur.timer + 8'h01;
         ev[IRQ_TIMER] = cur.timer == 8'hff;
      end

      // Event sources for the interrupt flags
      ev[IRQ_PORT] = |p6_changed;
      ev[IRQ_EXT] = int_stable && cur.int_state &&
         !cur.int_sync[2];

      // Data writes
      if (data_write_i) begin
         case (eff_addr)
            ADDR_TIMER: begin
               next_cur.timer = data_wdata_i;
               next_cur.prescale = '0;
            end
            ADDR_PC: begin
               if (!pc_low_write_i) begin
                  next_cur.pc = {cur.pc[9:8], data_wdata_i};
                  pc_changed = 1'b1;
               end
            end
            ADDR_STATUS: begin
               next_cur.status = data_wdata_i;
            end
            ADDR_RAM_SELECT: begin
               next_cur.ram_select = data_wdata_i | RAM_SELECT_FIXED;
            end
            ADDR_PORT5: next_cur.port5 = data_wdata_i & PORT5_MASK;
            ADDR_PORT6: next_cur.port6 = data_wdata_i;
            ADDR_TRIM_SIM: next_cur.trim = data_wdata_i & TRIM_MASK;
            ADDR_WAKEUP: next_cur.wakeup = data_wdata_i & WAKEUP_MASK;
            ADDR_IRQ_FLAGS: begin
               next_cur.irq_flags = cur.irq_flags &
                  data_wdata_i;
            end
            default: ;
         endcase
      end
      // Hardware set wins over a clearing write in the same cycle
      next_cur.irq_flags = (next_cur.irq_flags | ev) & IRQ_MASK;

      // Select pointer increment wraps inside six bits
      if (ram_select_increment_i) begin
         next_cur.ram_select = {RAM_SELECT_FIXED[7:6],
            6'(cur.ram_select[5:0] + 6'h01)};
      end

      // Status flags from the ALU
      if (flags_write_i) begin
         next_cur.status[STAT_CARRY] = flags_i[0];
         next_cur.status[STAT_HALF_CARRY] = flags_i[1];
         next_cur.status[STAT_ZERO] = flags_i[2];
      end
      if (next_cur.ram_select[5:0] == ADDR_GP_LAST &&
          cur.ram_select[5:0] != ADDR_GP_LAST) begin
         next_cur.status[STAT_ZERO] = 1'b1;
      end
      if (sleep_instruction_i) begin
         next_cur.status[STAT_POWER_DOWN] = 1'b0;
         next_cur.status[STAT_TIME_OUT] = 1'b1;
      end
      if (watchdog_clear_instruction_i) begin
         next_cur.status[STAT_POWER_DOWN] = 1'b1;
         next_cur.status[STAT_TIME_OUT] = 1'b1;
      end
      if (watchdog_expired_i) begin
         next_cur.status[STAT_TIME_OUT] = 1'b0;
      end

      // Program flow; the refill cycle accepts no new instruction
      if (instr_valid_i && cur.fetch == MCUOR_RUN) begin
         case (op_i)
            MCUOR_OP_JUMP: begin
               next_cur.pc = operand_i;
               pc_changed = 1'b1;
            end
            MCUOR_OP_CALL: begin
               for (int i = STACK_DEPTH - 1; i > 0; i--) begin
                  next_cur.stack[i] = cur.stack[i-1];
               end
               next_cur.stack[0] = pc_inc;
               next_cur.pc = operand_i;
               pc_changed = 1'b1;
            end
            MCUOR_OP_RETURN: begin
               next_cur.pc = cur.stack[0];
               for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                  next_cur.stack[i] = cur.stack[i+1];
               end
               pc_changed = 1'b1;
            end
            MCUOR_OP_ADD_PC: begin
               next_cur.pc = cur.pc + {2'b00, accumulator_i};
               pc_changed = 1'b1;
            end
            MCUOR_OP_STEP: begin
               if (!pc_changed) begin
                  next_cur.pc = pc_inc;
               end
            end
            default: ;
         endcase
      end
      // Any PC change costs one more instruction cycle
      next_cur.fetch = pc_changed ? MCUOR_REFILL : MCUOR_RUN;

      next_cur.rdata = data_read_i ? read_mux : cur.rdata;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cur <= '0;
         cur.pc <= PC_RESET;
         cur.status <= STATUS_RESET;
         cur.ram_select <= RAM_SELECT_RESET;
         cur.tpin_sync <= 3'b000;
         cur.int_sync <= 3'b111;
         cur.int_state <= 1'b1;
         cur.fetch <= MCUOR_RUN;
      end else begin
         cur <= next_cur;
      end
   end

   // General RAM is written through the same resolved address
   always_ff @(posedge clock_i) begin
      if (data_write_i && eff_addr >= ADDR_GP_FIRST) begin
         gp_ram[eff_addr] <= data_wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign data_rdata_o = cur.rdata;
   assign program_counter_o = cur.pc;
   assign stall_o = cur.fetch == MCUOR_REFILL;
   assign port5_data_o = cur.port5;
   assign port6_data_o = cur.port6;
   assign interrupt_flags_o = cur.irq_flags;
   assign prescaler_o = cur.prescale;
   // Wake request only while the enable bit is set
   assign port_change_wake_o = cur.wakeup[WAKE_PORT_CHANGE] &&
      |p6_changed;
endmodule

`default_nettype wire

// ### pkg/mcuor_pkg.sv
// Package: constants and types for the operational register page
package mcuor_pkg;
   // --------------------------------------------------------------
   // Register offsets
   // --------------------------------------------------------------
   localparam logic [5:0] ADDR_INDIRECT = 6'h00;
   localparam logic [5:0] ADDR_TIMER = 6'h01;
   localparam logic [5:0] ADDR_PC = 6'h02;
   localparam logic [5:0] ADDR_STATUS = 6'h03;
   localparam logic [5:0] ADDR_RAM_SELECT = 6'h04;
   localparam logic [5:0] ADDR_PORT5 = 6'h05;
   localparam logic [5:0] ADDR_PORT6 = 6'h06;
   localparam logic [5:0] ADDR_TRIM_SIM = 6'h0d;
   localparam logic [5:0] ADDR_WAKEUP = 6'h0e;
   localparam logic [5:0] ADDR_IRQ_FLAGS = 6'h0f;
   localparam logic [5:0] ADDR_GP_FIRST = 6'h10;
   localparam logic [5:0] ADDR_GP_LAST = 6'h3f;

   // --------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------
   localparam int STAT_CARRY = 0;
   localparam int STAT_HALF_CARRY = 1;
   localparam int STAT_ZERO = 2;
   localparam int STAT_POWER_DOWN = 3;
   localparam int STAT_TIME_OUT = 4;
   localparam int CTRL_PRESCALER_ASSIGN = 3;
   localparam int CTRL_EDGE_SELECT = 4;
   localparam int CTRL_TIMER_SOURCE = 5;
   localparam int WAKE_PORT_CHANGE = 1;
   localparam int IRQ_TIMER = 0;
   localparam int IRQ_PORT = 1;
   localparam int IRQ_EXT = 2;

   // --------------------------------------------------------------
   // Reset values and widths
   // --------------------------------------------------------------
   localparam int PC_WIDTH = 10;
   localparam logic [9:0] PC_RESET = 10'h000;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] RAM_SELECT_RESET = 8'hc0;
   localparam logic [7:0] RAM_SELECT_FIXED = 8'hc0;
   localparam logic [7:0] PORT5_MASK = 8'h7f;
   localparam logic [7:0] WAKEUP_MASK = 8'h02;
   localparam logic [7:0] IRQ_MASK = 8'h07;
   localparam logic [7:0] TRIM_MASK = 8'h0f;

   // Control-transfer operation presented by the core
   typedef enum logic [2:0] {
      MCUOR_OP_NONE = 3'b000,
      MCUOR_OP_JUMP = 3'b001,
      MCUOR_OP_CALL = 3'b011,
      MCUOR_OP_RETURN = 3'b010,
      MCUOR_OP_ADD_PC = 3'b110,
      MCUOR_OP_STEP = 3'b111
   } mcuor_op_type;

   // Program fetch state: extra cycle after any PC change
   typedef enum logic [0:0] {
      MCUOR_RUN = 1'b0,
      MCUOR_REFILL = 1'b1
   } mcuor_fetch_type;
endpackage

// ### verification/mcuor_core_model.sv
// Execution core stand-in: paces the instruction cycle tick
`timescale 1ns/1ps
`default_nettype none
module mcuor_core_model (
   input wire logic clock_i,
   input wire logic run_i,
   output logic instr_valid_o
);
   // One tick a clock; the fclk split is folded into clock_i
   always @(negedge clock_i) begin
      instr_valid_o <= run_i;
   end
endmodule
`default_nettype wire

// ### verification/mcuor_regs_chk.sv
// Checker: port timing relations of the operational register page
`timescale 1ns/1ps
`default_nettype none
module mcuor_chk #(
   parameter int PRESCALE_WIDTH = 8
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [5:0] data_addr_i,
   input wire logic data_read_i,
   input wire logic data_write_i,
   input wire logic [7:0] data_wdata_i,
   input wire logic pc_low_write_i,
   input wire logic [7:0] data_rdata_o,
   input wire logic instr_valid_i,
   input wire mcuor_pkg::mcuor_op_type op_i,
   input wire logic [9:0] operand_i,
   input wire logic [7:0] accumulator_i,
   input wire logic [9:0] program_counter_o,
   input wire logic stall_o,
   input wire logic [7:0] interrupt_mask_i,
   input wire logic [7:0] interrupt_flags_o,
   input wire logic [PRESCALE_WIDTH-1:0] prescaler_o
);
   import mcuor_pkg::*;
   logic take;
   // Ops only count outside the refill cycle
   assign take = instr_valid_i && !stall_o;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   AST_RESET_PC: assert property (disable iff (1'b0)
      !rst_n_i |-> program_counter_o == PC_RESET)
      else $error("pc not cleared in reset");
   AST_JUMP: assert property (take && op_i == MCUOR_OP_JUMP
      |=> program_counter_o == $past(operand_i))
      else $error("jump target not loaded");
   AST_ADD_PC: assert property (take && op_i == MCUOR_OP_ADD_PC
      |=> program_counter_o == $past(program_counter_o)
      + {2'b00, $past(accumulator_i)})
      else $error("pc add not full width");
   AST_CALL_RET: assert property (take && op_i == MCUOR_OP_CALL
      ##2 take && op_i == MCUOR_OP_RETURN
      |=> program_counter_o == $past(program_counter_o, 3) + 10'h001)
      else $error("return address wrong");
   AST_MOV_PC: assert property (data_write_i
      && data_addr_i == ADDR_PC && !pc_low_write_i && op_i == MCUOR_OP_NONE
      |=> program_counter_o == (($past(program_counter_o) & 10'h300)
      | {2'b00, $past(data_wdata_i)}))
      else $error("pc low write disturbed top bits");
   AST_REFILL: assert property (take && op_i inside {MCUOR_OP_JUMP,
      MCUOR_OP_CALL, MCUOR_OP_RETURN, MCUOR_OP_ADD_PC}
      |=> stall_o ##1 !stall_o)
      else $error("extra cycle missing");
   AST_PRESC_CLR: assert property (data_write_i
      && data_addr_i == ADDR_TIMER |=> prescaler_o == '0)
      else $error("prescaler not cleared");
   AST_IRQ_READ: assert property (data_read_i
      && data_addr_i == ADDR_IRQ_FLAGS |=> data_rdata_o
      == ($past(interrupt_flags_o) & $past(interrupt_mask_i)))
      else $error("flag read not masked");
   AST_SEL_TOP: assert property (data_read_i
      && data_addr_i == ADDR_RAM_SELECT |=> data_rdata_o[7:6] == 2'b11)
      else $error("select top bits not one");
endmodule

bind mcuor_regs mcuor_chk #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) mcuor_chk_i (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .data_addr_i(data_addr_i),
   .data_read_i(data_read_i), .data_write_i(data_write_i),
   .data_wdata_i(data_wdata_i), .pc_low_write_i(pc_low_write_i),
   .data_rdata_o(data_rdata_o), .instr_valid_i(instr_valid_i),
   .op_i(op_i), .operand_i(operand_i), .accumulator_i(accumulator_i),
   .program_counter_o(program_counter_o), .stall_o(stall_o),
   .interrupt_mask_i(interrupt_mask_i),
   .interrupt_flags_o(interrupt_flags_o), .prescaler_o(prescaler_o));
`default_nettype wire

// ### verification/tb_top.sv
// Testbench: directed scenarios for the operational register page
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mcuor_pkg::*;
   logic clock_i, rst_n_i, data_read_i, data_write_i, run, woke;
   logic [5:0] data_addr_i;
   logic [7:0] data_wdata_i, data_rdata_o, accumulator_i, rv;
   logic instr_valid_i, stall_o, flags_write_i, sleep_instruction_i;
   logic watchdog_clear_instruction_i, watchdog_expired_i;
   logic ram_select_increment_i, timer_pin_i, ext_irq_n_i;
   logic port_change_wake_o, pc_low_write_i;
   logic [9:0] operand_i, program_counter_o;
   logic [2:0] flags_i;
   logic [7:0] core_control_i, interrupt_mask_i, port6_pins_i;
   logic [7:0] port5_data_o, port6_data_o, interrupt_flags_o, prescaler_o;
   mcuor_op_type op_i;
   int error_cnt = 0;
   int num_checks = 0;

   mcuor_core_model mcuor_core_model_i (.clock_i, .run_i(run),
      .instr_valid_o(instr_valid_i));
   mcuor_regs mcuor_regs_i (.clock_i, .rst_n_i, .data_addr_i,
      .data_read_i, .data_write_i, .data_wdata_i, .pc_low_write_i,
      .data_rdata_o, .instr_valid_i, .op_i, .operand_i, .accumulator_i,
      .program_counter_o, .stall_o, .flags_write_i, .flags_i,
      .sleep_instruction_i, .watchdog_clear_instruction_i,
      .watchdog_expired_i, .ram_select_increment_i, .core_control_i,
      .interrupt_mask_i, .timer_pin_i, .ext_irq_n_i, .port6_pins_i,
      .port5_data_o, .port6_data_o, .interrupt_flags_o,
      .port_change_wake_o, .prescaler_o);

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk10(string n, logic [9:0] e, logic [9:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_sim;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Write strobe held for exactly one rising edge
   task automatic wr(logic [5:0] a, logic [7:0] d);
      @(negedge clock_i);
      data_addr_i = a;
      data_wdata_i = d;
      data_write_i = 1'b1;
      @(negedge clock_i);
      data_write_i = 1'b0;
   endtask
   // Read data is registered, so it is taken one edge later
   task automatic rd(logic [5:0] a, output logic [7:0] v);
      @(negedge clock_i);
      data_addr_i = a;
      data_read_i = 1'b1;
      @(negedge clock_i);
      data_read_i = 1'b0;
      v = data_rdata_o;
   endtask
   task automatic pls(ref logic s);
      @(negedge clock_i);
      s = 1'b1;
      @(negedge clock_i);
      s = 1'b0;
   endtask
   task automatic cf(mcuor_op_type o, logic [9:0] t, logic [7:0] a);
      @(negedge clock_i);
      op_i = o;
      operand_i = t;
      accumulator_i = a;
      @(negedge clock_i);
      op_i = MCUOR_OP_NONE;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk10("pc", PC_RESET, program_counter_o);
      rd(ADDR_STATUS, rv);
      chk8("status", STATUS_RESET, rv);
      rd(ADDR_RAM_SELECT, rv);
      chk8("select", RAM_SELECT_RESET, rv);
      rd(6'h07, rv);
      chk8("unmapped", 8'h00, rv);
   endtask
   task automatic t_ram;
      wr(ADDR_GP_FIRST, 8'h3c);
      wr(ADDR_GP_LAST, 8'hc3);
      rd(ADDR_GP_FIRST, rv);
      chk8("ram", 8'h3c, rv);
      rd(ADDR_GP_LAST, rv);
      chk8("ram", 8'hc3, rv);
      wr(ADDR_RAM_SELECT, 8'h10);
      wr(ADDR_INDIRECT, 8'h99);
      rd(ADDR_GP_FIRST, rv);
      chk8("indirect", 8'h99, rv);
      wr(ADDR_RAM_SELECT, 8'h3e);
      pls(ram_select_increment_i);
      rd(ADDR_STATUS, rv);
      chk8("zero", 8'h04, rv & 8'h04);
      rd(ADDR_RAM_SELECT, rv);
      chk8("select", 8'hff, rv);
      pls(ram_select_increment_i);
      rd(ADDR_RAM_SELECT, rv);
      chk8("select", 8'hc0, rv);
      wr(ADDR_PORT5, 8'hff);
      chk8("port5", 8'h7f, port5_data_o);
      wr(ADDR_PORT6, 8'ha5);
      chk8("port6", 8'ha5, port6_data_o);
   endtask
   task automatic t_status;
      @(negedge clock_i);
      flags_i = 3'b101;
      flags_write_i = 1'b1;
      @(negedge clock_i);
      flags_write_i = 1'b0;
      rd(ADDR_STATUS, rv);
      chk8("status", 8'h1d, rv);
      pls(sleep_instruction_i);
      rd(ADDR_STATUS, rv);
      chk8("status", 8'h15, rv);
      pls(watchdog_expired_i);
      rd(ADDR_STATUS, rv);
      chk8("status", 8'h05, rv);
      pls(watchdog_clear_instruction_i);
      rd(ADDR_STATUS, rv);
      chk8("status", 8'h1d, rv);
   endtask
   task automatic t_flow;
      cf(MCUOR_OP_JUMP, 10'h2f0, 8'h00);
      chk10("pc", 10'h2f0, program_counter_o);
      chk8("stall", 8'h01, {7'h00, stall_o});
      cf(MCUOR_OP_ADD_PC, 10'h000, 8'h20);
      chk10("pc", 10'h310, program_counter_o);
      cf(MCUOR_OP_CALL, 10'h155, 8'h00);
      chk10("pc", 10'h155, program_counter_o);
      cf(MCUOR_OP_RETURN, 10'h000, 8'h00);
      chk10("pc", 10'h311, program_counter_o);
      @(negedge clock_i);
      chk8("stall", 8'h00, {7'h00, stall_o});
      wr(ADDR_PC, 8'hab);
      chk10("pc", 10'h3ab, program_counter_o);
      // Counter write is dropped while the core holds it off
      pc_low_write_i = 1'b1;
      wr(ADDR_PC, 8'h12);
      chk10("pc", 10'h3ab, program_counter_o);
      pc_low_write_i = 1'b0;
      cf(MCUOR_OP_JUMP, 10'h3ff, 8'h00);
      cf(MCUOR_OP_STEP, 10'h000, 8'h00);
      chk10("pc", 10'h000, program_counter_o);
   endtask
   // Prescaler attached at 1:2; reads must leave it running
   task automatic t_presc;
      @(negedge clock_i);
      core_control_i = 8'h00;
      wr(ADDR_TIMER, 8'h00);
      repeat (9) @(negedge clock_i);
      rd(ADDR_TIMER, rv);
      chk8("timer", 8'h05, rv);
      chk8("prescale", 8'h0b, prescaler_o);
      rd(ADDR_TIMER, rv);
      chk8("timer", 8'h06, rv);
   endtask
   // Pin clocking: one rise, one fall, one rise after clearing
   task automatic t_timer;
      for (int m = 0; m < 2; m++) begin
         @(negedge clock_i);
         core_control_i = (m == 1) ? 8'h38 : 8'h28;
         timer_pin_i = 1'b0;
         repeat (8) @(negedge clock_i);
         wr(ADDR_TIMER, 8'h00);
         for (int k = 0; k < 3; k++) begin
            repeat (8) @(negedge clock_i);
            timer_pin_i = ~timer_pin_i;
         end
         repeat (8) @(negedge clock_i);
         rd(ADDR_TIMER, rv);
         chk8("timer", (m == 1) ? 8'h01 : 8'h02, rv);
      end
   endtask
   task automatic t_irq;
      int n;
      interrupt_mask_i = 8'h07;
      wr(ADDR_IRQ_FLAGS, 8'h00);
      core_control_i = 8'h08;
      wr(ADDR_TIMER, 8'hfa);
      for (n = 0; n < 64 && interrupt_flags_o[0] !== 1'b1; n++) begin
         @(negedge clock_i);
      end
      if (n == 64) begin
         error_cnt++;
         end_sim;
      end
      // Park the timer on the idle pin so it cannot wrap again
      core_control_i = 8'h28;
      ext_irq_n_i = 1'b0;
      port6_pins_i = 8'h01;
      repeat (8) @(negedge clock_i);
      chk8("flags", 8'h07, interrupt_flags_o);
      for (int b = 0; b < 3; b++) begin
         interrupt_mask_i = 8'h01 << b;
         rd(ADDR_IRQ_FLAGS, rv);
         chk8("masked", 8'h01 << b, rv);
      end
      wr(ADDR_IRQ_FLAGS, 8'hfe);
      chk8("flags", 8'h06, interrupt_flags_o);
      wr(ADDR_IRQ_FLAGS, 8'h00);
      wr(ADDR_IRQ_FLAGS, 8'hff);
      chk8("flags", 8'h00, interrupt_flags_o);
      for (int w = 1; w >= 0; w--) begin
         wr(ADDR_WAKEUP, (w == 1) ? 8'h02 : 8'h00);
         woke = 1'b0;
         port6_pins_i = port6_pins_i ^ 8'h02;
         // Wake output is a one-cycle pulse, so it is gathered here
         repeat (8) begin
            @(negedge clock_i);
            woke = woke | (port_change_wake_o === 1'b1);
         end
         chk8("wake", w[7:0], {7'h00, woke});
      end
   endtask

   // ------------------------------------------------------------
   // Clock and main sequence
   // ------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   initial begin
      {rst_n_i, data_read_i, data_write_i, run, woke, pc_low_write_i} = 6'h00;
      {data_addr_i, data_wdata_i, accumulator_i, operand_i} = '0;
      {flags_write_i, flags_i, sleep_instruction_i} = '0;
      {watchdog_clear_instruction_i, watchdog_expired_i} = '0;
      {ram_select_increment_i, timer_pin_i, port6_pins_i} = '0;
      {core_control_i, interrupt_mask_i} = '0;
      ext_irq_n_i = 1'b1;
      op_i = MCUOR_OP_NONE;
      repeat (6) @(negedge clock_i);
      rst_n_i = 1'b1;
      run = 1'b1;
      t_reset;
      t_ram;
      t_status;
      t_flow;
      t_presc;
      t_timer;
      t_irq;
      end_sim;
   end
endmodule
`default_nettype wire
